/* rtl/eamc_consts.svh */
`ifndef EAMC_CONSTS_SVH
`define EAMC_CONSTS_SVH

// =====================================================================
// register word indexes (byte address = index * 4)
`define EAMC_ACCUMULATION_MODE_UPPER_IDX    16'he701
`define EAMC_LCYC_IDX       16'he702
`define EAMC_STATUS_IDX     16'he600
`define EAMC_MASK_IDX       16'he601
`define EAMC_HALF_CYCLE_COUNT_IDX    16'he602
`define EAMC_ENERGY_IDX     16'he400
`define EAMC_ENERGY_SLOTS   16'h000c

// =====================================================================
// reset values
`define EAMC_ACCUMULATION_MODE_UPPER_RST    8'h80
`define EAMC_LCYC_RST       8'h78
`define EAMC_HALF_CYCLE_COUNT_RST    16'h00ff

// =====================================================================
// field positions
`define EAMC_CONSEL_LSB     4
`define EAMC_REVSEL_BIT     6
`define EAMC_WATT_LINECYCLE_ENABLE_BIT      0
`define EAMC_VAR_LINECYCLE_ENABLE_BIT       1
`define EAMC_LVA_BIT        2
`define EAMC_ZERO_CROSS_PHASE_SELECT_LSB      3
`define EAMC_READ_CLEARS_ENERGY_BIT    6
`define EAMC_POWER_FACTOR_SOURCE_BIT     7
`define EAMC_ST_LCYC_BIT    0
`define EAMC_ST_PF_BIT      1
`define EAMC_ST_REV_LSB     6
`define EAMC_ST_WIDTH       9

`endif

/* rtl/eamc_pkg.sv */
package eamc_pkg;

  // =====================================================================
  // wiring configuration
  typedef enum logic [1:0] {
    EAMC_WYE3    = 2'h0,
    EAMC_DELTA3W = 2'h1,
    EAMC_WYE2    = 2'h2,
    EAMC_DELTA4W = 2'h3
  } eamc_consel_e;

  // per-phase samples from the signal path
  typedef struct packed {
    logic signed [15:0] v;
    logic signed [15:0] i;
    logic signed [15:0] i_fund;
    logic signed [15:0] i_quad;
    logic        [15:0] vrms;
    logic        [15:0] irms;
  } eamc_phase_s;

  // power factor operands: active over apparent
  typedef struct packed {
    logic signed [31:0] watt;
    logic        [31:0] va;
  } eamc_pf_s;

endpackage : eamc_pkg

/* rtl/eamc_top.sv */
// Function
// - select bit 0: total active power sign drives reversal flags, status bits 6..8
// - select bit 1: fundamental active power drives the same reversal flags
// - reversal select at bit 6 resets 0; bit 7 resets 1, no function
// - three-wire delta: phase B rms register carries line voltage A-C rms
// - bit 0 puts six watt-hour registers into line-cycle accumulation
// - bit 1 puts three fundamental var-hour registers into line-cycle accumulation
// - bit 2 puts three VA-hour registers into line-cycle accumulation
// - bits 3..5 include phases A..C in zero-crossing count, reset 1
// - crossings of all selected phases are counted, shortening the period
// - bit 6 set: reading an energy register returns it then clears it
// - bit 7 clear: power factor from instantaneous phase powers
// - energy power factor updates once per programmed half-cycle count
// - connection select codes: 00 wye3, 01 delta3w, 10 wye2, 11 delta4w
// - reactive products use quadrature-shifted current times phase voltage
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "eamc_consts.svh"
module eamc_top (
  input  wire logic                           i_core_clk,
  input  wire logic                           i_srst,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [17:0]                    i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  output logic      [31:0]                    o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  input  wire logic                           i_sample_vld,
  input  wire eamc_pkg::eamc_phase_s [2:0]    i_phase,
  input  wire logic [15:0]                    i_vrms_line_ac,
  input  wire logic [2:0]                     i_zx,
  output logic                                o_irq,
  output logic signed [16:0]                  o_phase_b_voltage,
  output logic      [15:0]                    o_phase_b_voltage_rms,
  output eamc_pkg::eamc_pf_s [2:0]            o_pf,
  output logic                                o_line_cycle_end
);
  import eamc_pkg::*;

  localparam int NS = 12;

  // =====================================================================
  // helpers
  function automatic logic signed [31:0] smul(input logic signed [16:0] a, input logic signed [15:0] b);
    logic signed [32:0] p;
    p = a * b;
    return p[31:0];
  endfunction : smul

  // slots 0..5 watt, 6..8 fundamental var, 9..11 VA
  function automatic logic lc_on(input int s, input logic [7:0] m);
    logic r;
    r = (s < 6) ? m[`EAMC_WATT_LINECYCLE_ENABLE_BIT] : (s < 9) ? m[`EAMC_VAR_LINECYCLE_ENABLE_BIT] : m[`EAMC_LVA_BIT];
    return r;
  endfunction : lc_on

  // =====================================================================
  // state
  logic [7:0]                 accumulation_mode_upper_q;
  logic [7:0]                 lcyc_q;
  logic [15:0]                half_cycle_count_q;
  logic [`EAMC_ST_WIDTH-1:0]  status_q;
  logic [`EAMC_ST_WIDTH-1:0]  status_d;
  logic [`EAMC_ST_WIDTH-1:0]  mask_q;
  logic [`EAMC_ST_WIDTH-1:0]  st_set;
  logic [`EAMC_ST_WIDTH-1:0]  st_clr;
  logic                       irq_q;
  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;
  logic signed [31:0]         vis_q [NS];
  logic signed [31:0]         acc_q [NS];
  logic signed [31:0]         prod [NS];
  logic signed [31:0]         add [NS];
  logic signed [31:0]         lc_val [NS];
  logic [15:0]                zx_cnt_q;
  logic [16:0]                zx_sum;
  logic [1:0]                 zx_n;
  logic [2:0]                 zx_hit;
  logic                       lc_end;
  logic                       lc_end_q;
  logic [2:0]                 sign_q;
  logic [2:0]                 rev_evt;
  logic signed [16:0]         vb_map;
  logic signed [16:0]         vb_q;
  logic [15:0]                vbrms_q;
  eamc_pf_s [2:0]             pf_q;
  eamc_consel_e               consel;

  logic [15:0]                word;
  logic                       en_hit;
  logic [3:0]                 slot;
  logic                       mapped;
  logic [31:0]                rd_mux;
  logic                       acc_wr;
  logic                       acc_rd;
  logic                       rdclr;

  assign consel = eamc_consel_e'(accumulation_mode_upper_q[`EAMC_CONSEL_LSB +: 2]);

  // =====================================================================
  // phase B voltage and power products
  always_comb begin
    unique case (consel)
      EAMC_WYE3:    vb_map = 17'(i_phase[1].v);
      EAMC_DELTA3W: vb_map = 17'(i_phase[0].v) - 17'(i_phase[2].v);
      EAMC_WYE2:    vb_map = -17'(i_phase[0].v) - 17'(i_phase[2].v);
      EAMC_DELTA4W: vb_map = -17'(i_phase[0].v);
    endcase
  end

  always_comb begin
    logic signed [16:0] vs;
    logic [15:0]        vr;
    vs = 17'sh0;
    vr = 16'h0;
    for (int p = 0; p < 3; p++) begin
      vs = (p == 1) ? vb_map : 17'(i_phase[p].v);
      vr = (p == 1 && consel == EAMC_DELTA3W) ? i_vrms_line_ac : i_phase[p].vrms;
      prod[p]     = smul(vs, i_phase[p].i);
      prod[3 + p] = smul(vs, i_phase[p].i_fund);
      prod[6 + p] = smul(vs, i_phase[p].i_quad);
      prod[9 + p] = $signed(32'(vr) * 32'(i_phase[p].irms));
    end
    for (int s = 0; s < NS; s++) begin
      add[s]    = i_sample_vld ? prod[s] : 32'sh0;
      lc_val[s] = acc_q[s] + add[s];
    end
  end

  // =====================================================================
  // zero-crossing count and line-cycle period
  always_comb begin
    zx_hit = i_zx & lcyc_q[`EAMC_ZERO_CROSS_PHASE_SELECT_LSB +: 3];
    zx_n   = 2'(zx_hit[0]) + 2'(zx_hit[1]) + 2'(zx_hit[2]);
    zx_sum = 17'(zx_cnt_q) + 17'(zx_n);
    lc_end = (zx_n != 2'h0) && (zx_sum >= {1'b0, half_cycle_count_q});
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      zx_cnt_q <= 16'h0;
      lc_end_q <= 1'b0;
    end else begin
      zx_cnt_q <= lc_end ? 16'h0 : zx_sum[15:0];
      lc_end_q <= lc_end;
    end
  end

  // =====================================================================
  // apb decode
  always_comb begin
    word   = i_paddr[17:2];
    en_hit = (word >= `EAMC_ENERGY_IDX) && (word < `EAMC_ENERGY_IDX + `EAMC_ENERGY_SLOTS);
    slot   = 4'(word - `EAMC_ENERGY_IDX);
    mapped = (i_paddr[1:0] == 2'h0) &&
             (en_hit || word == `EAMC_ACCUMULATION_MODE_UPPER_IDX || word == `EAMC_LCYC_IDX ||
              word == `EAMC_STATUS_IDX || word == `EAMC_MASK_IDX || word == `EAMC_HALF_CYCLE_COUNT_IDX);
    rd_mux = 32'h0;
    if (en_hit) begin
      rd_mux = vis_q[slot];
    end else if (word == `EAMC_ACCUMULATION_MODE_UPPER_IDX) begin
      rd_mux = 32'(accumulation_mode_upper_q);
    end else if (word == `EAMC_LCYC_IDX) begin
      rd_mux = 32'(lcyc_q);
    end else if (word == `EAMC_STATUS_IDX) begin
      rd_mux = 32'(status_q);
    end else if (word == `EAMC_MASK_IDX) begin
      rd_mux = 32'(mask_q);
    end else if (word == `EAMC_HALF_CYCLE_COUNT_IDX) begin
      rd_mux = 32'(half_cycle_count_q);
    end
    acc_wr = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
    acc_rd = i_psel && i_penable && pready_q && !i_pwrite && !pslverr_q;
    rdclr  = acc_rd && en_hit && lcyc_q[`EAMC_READ_CLEARS_ENERGY_BIT];
  end

  // no wait state: read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (i_psel && !i_penable) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q  <= (mapped && !i_pwrite) ? rd_mux : 32'h0;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // =====================================================================
  // configuration registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      accumulation_mode_upper_q <= `EAMC_ACCUMULATION_MODE_UPPER_RST;
      lcyc_q    <= `EAMC_LCYC_RST;
      half_cycle_count_q <= `EAMC_HALF_CYCLE_COUNT_RST;
      mask_q    <= '0;
    end else if (acc_wr) begin
      if (word == `EAMC_ACCUMULATION_MODE_UPPER_IDX) accumulation_mode_upper_q <= i_pwdata[7:0];
      if (word == `EAMC_LCYC_IDX) lcyc_q <= i_pwdata[7:0];
      if (word == `EAMC_HALF_CYCLE_COUNT_IDX) half_cycle_count_q <= i_pwdata[15:0];
      if (word == `EAMC_MASK_IDX) mask_q <= i_pwdata[`EAMC_ST_WIDTH-1:0];
    end
  end

  // =====================================================================
  // energy registers
  // a read-clear subtracts the captured value, so a sample landing between
  // setup and access is kept rather than lost
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      for (int s = 0; s < NS; s++) begin
        vis_q[s] <= 32'sh0;
        acc_q[s] <= 32'sh0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (lc_on(s, lcyc_q)) begin
          acc_q[s] <= lc_end ? 32'sh0 : lc_val[s];
          if (lc_end) begin
            vis_q[s] <= lc_val[s];
          end else if (rdclr && slot == 4'(s)) begin
            vis_q[s] <= vis_q[s] - $signed(prdata_q);
          end
        end else begin
          acc_q[s] <= 32'sh0;
          vis_q[s] <= vis_q[s] + add[s] - ((rdclr && slot == 4'(s)) ? $signed(prdata_q) : 32'sh0);
        end
      end
    end
  end

  // =====================================================================
  // reversal detection
  always_comb begin
    logic signed [31:0] rp;
    rp = 32'sh0;
    for (int p = 0; p < 3; p++) begin
      rp = accumulation_mode_upper_q[`EAMC_REVSEL_BIT] ? prod[3 + p] : prod[p];
      rev_evt[p] = i_sample_vld && (rp[31] != sign_q[p]);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sign_q <= 3'h0;
    end else if (i_sample_vld) begin
      for (int p = 0; p < 3; p++) begin
        sign_q[p] <= accumulation_mode_upper_q[`EAMC_REVSEL_BIT] ? prod[3 + p][31] : prod[p][31];
      end
    end
  end

  // =====================================================================
  // status, mask, interrupt
  always_comb begin
    st_set = '0;
    st_set[`EAMC_ST_REV_LSB +: 3] = rev_evt;
    st_set[`EAMC_ST_LCYC_BIT]     = lc_end && (lcyc_q[2:0] != 3'h0);
    st_set[`EAMC_ST_PF_BIT]       = lc_end && lcyc_q[`EAMC_POWER_FACTOR_SOURCE_BIT];
    st_clr   = (acc_wr && word == `EAMC_STATUS_IDX) ? i_pwdata[`EAMC_ST_WIDTH-1:0] : '0;
    status_d = (status_q & ~st_clr) | st_set;  // set beats clear
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // =====================================================================
  // power factor operands and phase B voltage outputs
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pf_q <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (lcyc_q[`EAMC_POWER_FACTOR_SOURCE_BIT]) begin
          if (lc_end) begin
            pf_q[p].watt <= lc_val[p];
            pf_q[p].va   <= lc_val[9 + p];
          end
        end else if (i_sample_vld) begin
          pf_q[p].watt <= prod[p];
          pf_q[p].va   <= prod[9 + p];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      vb_q    <= 17'sh0;
      vbrms_q <= 16'h0;
    end else if (i_sample_vld) begin
      vb_q    <= vb_map;
      vbrms_q <= (consel == EAMC_DELTA3W) ? i_vrms_line_ac : i_phase[1].vrms;
    end
  end

  assign o_prdata              = prdata_q;
  assign o_pready              = pready_q;
  assign o_pslverr             = pslverr_q;
  assign o_irq                 = irq_q;
  assign o_phase_b_voltage     = vb_q;
  assign o_phase_b_voltage_rms = vbrms_q;
  assign o_pf                  = pf_q;
  assign o_line_cycle_end      = lc_end_q;

endmodule : eamc_top

/* sim/eamc_top_monitor.sv */
`timescale 1ns/1ps
`include "eamc_consts.svh"
// =====================================================================
// apb timing and sampled datapath checks
module eamc_top_monitor
  import eamc_pkg::*;
(
  input wire logic                        i_core_clk,
  input wire logic                        i_srst,
  input wire logic                        i_psel,
  input wire logic                        i_penable,
  input wire logic                        i_pwrite,
  input wire logic [17:0]                 i_paddr,
  input wire logic [31:0]                 i_pwdata,
  input wire logic [31:0]                 o_prdata,
  input wire logic                        o_pready,
  input wire logic                        o_pslverr,
  input wire logic                        i_sample_vld,
  input wire eamc_pkg::eamc_phase_s [2:0] i_phase,
  input wire logic [15:0]                 i_vrms_line_ac,
  input wire logic signed [16:0]          o_phase_b_voltage,
  input wire logic [15:0]                 o_phase_b_voltage_rms,
  input wire eamc_pkg::eamc_pf_s [2:0]    o_pf
);
  logic        [1:0]  consel_q;
  logic               power_factor_source_q;
  logic signed [16:0] vb_exp;
  wire                wr_ok  = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
  wire signed  [16:0] va     = $signed(i_phase[0].v);
  wire signed  [16:0] vc     = $signed(i_phase[2].v);
  wire signed  [31:0] watt_a = $signed(i_phase[0].v) * $signed(i_phase[0].i);
  wire         [31:0] va_a   = i_phase[0].vrms * i_phase[0].irms;

  // =====================================================================
  // shadow copies of the mode fields, tracked from completed writes only
  always_ff @(posedge i_core_clk) begin
    if (i_srst) consel_q <= 2'h0;
    else if (wr_ok && i_paddr[17:2] == `EAMC_ACCUMULATION_MODE_UPPER_IDX) consel_q <= i_pwdata[5:4];
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) power_factor_source_q <= 1'b0;
    else if (wr_ok && i_paddr[17:2] == `EAMC_LCYC_IDX) power_factor_source_q <= i_pwdata[7];
  end
  always_comb begin
    case (consel_q)
      2'h0:    vb_exp = $signed(i_phase[1].v);
      2'h1:    vb_exp = va - vc;
      2'h2:    vb_exp = -va - vc;
      default: vb_exp = -va;
    endcase
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_has_setup: assert property (o_pready |-> i_psel && i_penable && $past(i_psel && !i_penable))
    else $error("ready without setup");
  a_error_reads_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error without ready or with data");
  a_misaligned_refused: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'h0 |=> o_pslverr)
    else $error("misaligned access accepted");
  a_rdata_holds: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data moved without setup");
  a_phase_b_map: assert property (i_sample_vld |=> o_phase_b_voltage == $past(vb_exp))
    else $error("phase b voltage mapping");
  a_delta_rms: assert property (i_sample_vld && consel_q == 2'h1 |=> o_phase_b_voltage_rms == $past(i_vrms_line_ac))
    else $error("phase b rms in delta");
  a_pf_instant: assert property (i_sample_vld && !power_factor_source_q |=> o_pf[0].watt == $past(watt_a) && o_pf[0].va == $past(va_a))
    else $error("instantaneous pf operands");
  c_write: cover property (wr_ok);
  c_error: cover property (o_pslverr);
  c_delta: cover property (i_sample_vld && consel_q == 2'h1);
endmodule : eamc_top_monitor

bind eamc_top eamc_top_monitor u_mon (.i_core_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_prdata, .o_pready, .o_pslverr, .i_sample_vld, .i_phase, .i_vrms_line_ac, .o_phase_b_voltage,
  .o_phase_b_voltage_rms, .o_pf);

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "eamc_consts.svh"
// =====================================================================
// self-checking bench driving apb, samples and zero crossings
module testbench;
  import eamc_pkg::*;
  localparam logic [15:0] ST = `EAMC_STATUS_IDX;
  localparam logic [15:0] EN = `EAMC_ENERGY_IDX;
  localparam logic [15:0] AC = `EAMC_ACCUMULATION_MODE_UPPER_IDX;
  localparam logic [15:0] LC = `EAMC_LCYC_IDX;
  logic               i_core_clk, i_srst, i_psel, i_penable, i_pwrite, i_sample_vld;
  logic        [17:0] i_paddr;
  logic        [31:0] i_pwdata, o_prdata, q;
  logic               o_pready, o_pslverr, o_irq, o_line_cycle_end, e;
  eamc_phase_s [2:0]  i_phase;
  logic        [15:0] i_vrms_line_ac, o_phase_b_voltage_rms;
  logic        [2:0]  i_zx;
  logic signed [16:0] o_phase_b_voltage;
  eamc_pf_s    [2:0]  o_pf;
  int                 fails, check_count, lce_n, n0;

  eamc_top DUT (.i_core_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_sample_vld, .i_phase, .i_vrms_line_ac, .i_zx, .o_irq, .o_phase_b_voltage,
    .o_phase_b_voltage_rms, .o_pf, .o_line_cycle_end);

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) if (o_line_cycle_end === 1'b1) lce_n++;

  // =====================================================================
  // shared drivers
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    check_count++;
    if (got !== x) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, x);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [31:0] x);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    chk(q, x);
  endtask : rd
  // phase a operands change together with the sample strobe
  task automatic smp(input logic signed [15:0] v, input logic signed [15:0] i, input logic signed [15:0] f);
    @(posedge i_core_clk);
    i_phase[0].v      <= v;
    i_phase[0].i      <= i;
    i_phase[0].i_fund <= f;
    i_sample_vld      <= 1'b1;
    @(posedge i_core_clk);
    i_sample_vld      <= 1'b0;
    #1;
  endtask : smp
  task automatic zx(input logic [2:0] b);
    @(posedge i_core_clk);
    i_zx <= b;
    @(posedge i_core_clk);
    i_zx <= 3'h0;
    repeat (2) @(posedge i_core_clk);
  endtask : zx

  // =====================================================================
  // scenarios
  task automatic t_bus;
    rd(AC, 32'h80);
    rd(LC, 32'h78);
    rd(ST, 32'h0);
    wr(AC, 32'hff);
    rd(AC, 32'hff);
    apb(1'b0, 18'h0, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, {AC, 2'b01}, 32'h0);
    chk({31'h0, e}, 32'h1);
    rd(AC, 32'hff);
  endtask : t_bus
  task automatic t_consel;
    logic signed [16:0] xv [4] = '{-17'sd7, 17'sd70, -17'sd130, -17'sd100};
    for (int c = 0; c < 4; c++) begin
      wr(AC, 32'(c) << 4); // pulse converters sit outside; their phase b terms are software's
      smp(16'sd100, 16'sd0, 16'sd0);
      chk(32'(o_phase_b_voltage), 32'(xv[c]));
      chk(o_phase_b_voltage_rms, c == 1 ? 16'h1234 : 16'h0055);
    end
    rd(ST, 32'h80);
  endtask : t_consel
  task automatic t_reversal;
    wr(AC, 32'h0);
    wr(`EAMC_MASK_IDX, 32'h40);
    smp(16'sd2, 16'sd3, 16'sd3);
    wr(ST, 32'h1ff);
    rd(ST, 32'h0);
    smp(16'sd2, -16'sd3, 16'sd3);
    rd(ST, 32'h40);
    chk(o_irq, 1'b1);
    wr(`EAMC_MASK_IDX, 32'h0);
    rd(ST, 32'h40);
    chk(o_irq, 1'b0);
    smp(16'sd2, 16'sd3, 16'sd3);
    wr(ST, 32'h1ff);
    wr(AC, 32'h40);
    smp(16'sd2, -16'sd3, 16'sd3);
    rd(ST, 32'h0);
    smp(16'sd2, -16'sd3, -16'sd3);
    rd(ST, 32'h40);
    wr(ST, 32'h1ff);
  endtask : t_reversal
  task automatic t_read_clear;
    for (int s = 0; s < 12; s += 3) apb(1'b0, {EN + 16'(s), 2'b00}, 32'h0);
    smp(16'sd2, 16'sd3, 16'sd4);
    smp(16'sd2, 16'sd3, 16'sd4);
    rd(EN, 32'd12);
    rd(EN + 16'h3, 32'd16);
    rd(EN + 16'h6, 32'd20);
    rd(EN + 16'h9, 32'd84);
    rd(EN, 32'd0);
    wr(LC, 32'h38);
    smp(16'sd2, 16'sd3, 16'sd4);
    rd(EN, 32'd6);
    rd(EN, 32'd6);
  endtask : t_read_clear
  task automatic t_line_cycle;
    wr(`EAMC_HALF_CYCLE_COUNT_IDX, 32'h2);
    wr(LC, 32'h8f);
    zx(3'h1);
    zx(3'h1);
    wr(ST, 32'h1ff);
    n0 = lce_n;
    repeat (3) smp(16'sd2, 16'sd3, 16'sd4);
    zx(3'h2);
    zx(3'h1);
    chk(32'(lce_n), 32'(n0));
    zx(3'h1);
    chk(32'(lce_n), 32'(n0 + 1));
    rd(EN, 32'd18);
    rd(EN + 16'h6, 32'd30);
    rd(EN + 16'h9, 32'd126);
    chk(o_pf[0].watt, 32'd18);
    chk(o_pf[0].va, 32'd126);
    rd(ST, 32'h3);
    wr(`EAMC_HALF_CYCLE_COUNT_IDX, 32'h3);
    wr(LC, 32'hbf);
    n0 = lce_n;
    zx(3'h7);
    chk(32'(lce_n), 32'(n0 + 1));
  endtask : t_line_cycle

  // =====================================================================
  // main sequence and watchdog
  initial begin
    {i_srst, i_psel, i_penable, i_pwrite, i_sample_vld} = 5'b10000;
    {i_paddr, i_pwdata, i_zx} = '0;
    i_vrms_line_ac = 16'h1234;
    i_phase[0] = '{16'sd100, 16'sd0, 16'sd0, 16'sd5, 16'h6, 16'h7};
    i_phase[1] = '{-16'sd7, 16'sd1, 16'sd1, 16'sd0, 16'h55, 16'h0};
    i_phase[2] = '{16'sd30, 16'sd1, 16'sd1, 16'sd0, 16'h0, 16'h0};
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    t_bus();
    t_consel();
    t_reversal();
    t_read_clear();
    t_line_cycle();
    summarize();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_core_clk);
    fails++;
    summarize();
  end
endmodule : testbench
